// ### core/amac_pkg.sv
// Purpose: shared constants and types of the execute datapath
// Assumes: 32-bit AHB-Lite register window, byte offsets below 0x100
// Notes: all control state resets to zero
`default_nettype none
package amac_pkg;
   localparam logic [7:0] ADDR_OPA = 8'h00;
   localparam logic [7:0] ADDR_OPB = 8'h04;
   localparam logic [7:0] ADDR_OPC = 8'h08;
   localparam logic [7:0] ADDR_CTRL = 8'h0C;
   localparam logic [7:0] ADDR_SR = 8'h10;
   localparam logic [7:0] ADDR_RESHI = 8'h14;
   localparam logic [7:0] ADDR_ACCLO = 8'h18;
   localparam logic [7:0] ADDR_ACCHI = 8'h1C;
   localparam logic [7:0] ADDR_STAT = 8'h20;
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_OFS_LSB = 8;
   localparam int CTRL_WID_LSB = 16;
   localparam int CTRL_PARTX_BIT = 24;
   localparam int CTRL_PARTY_BIT = 25;
   localparam int CTRL_IMM_BIT = 26;
   localparam int CTRL_COND_LSB = 28;
   localparam int SR_C = 0;
   localparam int SR_Z = 1;
   localparam int SR_N = 2;
   localparam int SR_V = 3;
   localparam int SR_Q = 4;
   localparam logic [4:0] SSRF_LONG_MIN = 5'h10;
   localparam logic [1:0] SSRF_EXTRA = 2'h2;
   localparam logic [63:0] ROUND_K = 64'h0000_0000_0000_8000;
   typedef enum logic [5:0] {
      OP_OR_HIGH, OP_OR_LOW, OP_TEST, OP_FIELD_INS, OP_FIELD_EXT_S,
      OP_FIELD_EXT_U, OP_BIT_CLR, OP_BIT_SET, OP_CAST_SB, OP_CAST_SH,
      OP_CAST_UB, OP_CAST_UH, OP_SWAP_WORD, BYTE_EXCHANGE_PER_HALF_OP,
      OP_SWAP_HALVES, OP_SHIFT_AR, OP_SHIFT_LL, OP_SHIFT_LR, OP_ROT_L,
      OP_ROT_R, CONDITIONAL_MOVE_OP, OP_LOAD_HIGH, OP_FLAG_CLR,
      OP_FLAG_COPY, OP_FLAG_SET, CONDITIONAL_BOOLEAN_OP, OP_MUL,
      OP_MULHH, OP_MULNHH, OP_MULWH, OP_MULNWH, OP_MULSATHH_H,
      OP_MULSATHH_W, OP_MULSATWH, OP_MULSATRNDHH, OP_MULSATRNDWH,
      OP_MAC, OP_MACHH_W, OP_MACHH_D, OP_MACWH_D, OP_MACSATHH_W
   } amac_op_type;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ACC_READ = 2'h2,
      ST_EXEC = 2'h1,
      ST_FLAG_WAIT = 2'h3
   } amac_state_type;
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } amac_ahb_req_type;
   typedef struct packed {
      logic dp_act;
      logic dp_wr;
      logic [7:0] dp_addr;
      amac_state_type st;
      logic [1:0] wait_cnt;
      logic [31:0] opa;
      logic [31:0] opb;
      logic [31:0] opc;
      logic [31:0] ctrl;
      logic [31:0] sr;
      logic [31:0] res_hi;
      logic [31:0] acc_lo;
      logic [15:0] acc_hi;
      logic [47:0] hold;
      logic hold_ok;
      logic [31:0] rdata;
   } amac_regs_type;
endpackage
`default_nettype wire

// ### core/amac_datapath.sv
// Purpose: bit-manipulation, multiply and multiply-accumulate datapath
// Assumes: single AHB-Lite slave, one op at a time, word accesses only
// Notes: destination register lives in OPA, wait states while busy
//
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module amac_datapath #(
   parameter int CORE_REV = 2
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire amac_pkg::amac_ahb_req_type i_ahb,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic o_busy
);
   amac_pkg::amac_regs_type s, next_s;
   amac_pkg::amac_op_type op, op_w;
   logic busy, bus_wr, start, mac_w, cond_ok, min_hh, min_wh, sovf;
   logic [4:0] ofs, wid, amt;
   logic [3:0] cond;
   logic [31:0] rd, rs, ry, mask, fld, sum32, psat;
   logic [15:0] hx, hy;
   logic signed [31:0] mx, my;
   logic signed [63:0] prod;
   logic [63:0] frac, rnd;
   logic [47:0] sum48;
   logic [32:0] ssum;

   function automatic logic cond_eval(input logic [3:0] c,
                                      input logic [31:0] f);
      logic zf, cf, nf, vf;
      zf = f[amac_pkg::SR_Z];
      cf = f[amac_pkg::SR_C];
      nf = f[amac_pkg::SR_N];
      vf = f[amac_pkg::SR_V];
      unique case (c)
         4'h0: cond_eval = zf;
         4'h1: cond_eval = !zf;
         4'h2: cond_eval = !cf;
         4'h3: cond_eval = cf;
         4'h4: cond_eval = (nf == vf);
         4'h5: cond_eval = (nf != vf);
         4'h6: cond_eval = nf;
         4'h7: cond_eval = !nf;
         4'h8: cond_eval = cf | zf;
         4'h9: cond_eval = !zf & (nf == vf);
         4'hA: cond_eval = zf | (nf != vf);
         4'hB: cond_eval = !cf & !zf;
         4'hC: cond_eval = vf;
         4'hD: cond_eval = !vf;
         4'hE: cond_eval = f[amac_pkg::SR_Q];
         4'hF: cond_eval = 1'b1;
      endcase
   endfunction

   function automatic logic is_mac(input amac_pkg::amac_op_type o);
      is_mac = o inside {amac_pkg::OP_MAC, amac_pkg::OP_MACHH_W,
                         amac_pkg::OP_MACHH_D, amac_pkg::OP_MACWH_D,
                         amac_pkg::OP_MACSATHH_W};
   endfunction

   // operand decode and the one shared multiplier array
   always_comb begin
      op = amac_pkg::amac_op_type'(s.ctrl[amac_pkg::CTRL_OP_LSB +: 6]);
      op_w = amac_pkg::amac_op_type'(i_ahb.hwdata[amac_pkg::CTRL_OP_LSB +: 6]);
      ofs = s.ctrl[amac_pkg::CTRL_OFS_LSB +: 5];
      wid = s.ctrl[amac_pkg::CTRL_WID_LSB +: 5];
      cond = s.ctrl[amac_pkg::CTRL_COND_LSB +: 4];
      rd = s.opa;
      rs = s.opb;
      ry = s.opc;
      amt = s.ctrl[amac_pkg::CTRL_IMM_BIT] ? ofs : ry[4:0];
      cond_ok = cond_eval(cond, s.sr);
      mask = (32'h0000_0001 << wid) - 32'h0000_0001;
      fld = (rs >> ofs) & mask;
      hx = s.ctrl[amac_pkg::CTRL_PARTX_BIT] ? rs[31:16] : rs[15:0];
      hy = s.ctrl[amac_pkg::CTRL_PARTY_BIT] ? ry[31:16] : ry[15:0];
      // halfword-x forms feed a sign-extended half, word forms the word
      if (op inside {amac_pkg::OP_MULHH, amac_pkg::OP_MULNHH,
                     amac_pkg::OP_MULSATHH_H, amac_pkg::OP_MULSATHH_W,
                     amac_pkg::OP_MULSATRNDHH, amac_pkg::OP_MACHH_W,
                     amac_pkg::OP_MACHH_D, amac_pkg::OP_MACSATHH_W}) begin
         mx = {{16{hx[15]}}, hx};
      end else begin
         mx = rs;
      end
      if (op inside {amac_pkg::OP_MUL, amac_pkg::OP_MAC}) begin
         my = ry;
      end else begin
         my = {{16{hy[15]}}, hy};
      end
      prod = mx * my;
      frac = {prod[62:0], 1'b0};
      rnd = frac + amac_pkg::ROUND_K;
      min_hh = (hx == 16'h8000) && (hy == 16'h8000);
      min_wh = (rs == 32'h8000_0000) && (hy == 16'h8000);
      sum32 = s.hold[31:0] + prod[31:0];
      sum48 = s.hold + prod[47:0];
      psat = min_hh ? 32'h7FFF_FFFF : frac[31:0];
      ssum = {s.hold[31], s.hold[31:0]} + {psat[31], psat};
      sovf = ssum[32] != ssum[31];
   end
   always_comb begin
      busy = s.st != amac_pkg::ST_IDLE;
      // a data phase waits while an operation is still in flight
      o_hreadyout = !(s.dp_act && busy);
      o_hresp = 1'b0;
      o_busy = busy;
      bus_wr = s.dp_act && s.dp_wr && o_hreadyout;
      start = bus_wr && (s.dp_addr == amac_pkg::ADDR_CTRL);
      mac_w = is_mac(op_w);
      o_hrdata = s.rdata;
   end

   always_comb begin
      next_s = s;
      if (i_ahb.hready) begin
         next_s.dp_act = i_ahb.hsel && i_ahb.htrans[1];
         next_s.dp_wr = i_ahb.hwrite;
         next_s.dp_addr = i_ahb.haddr[7:0];
      end
      if (bus_wr) begin
         unique case (s.dp_addr)
            amac_pkg::ADDR_OPA: next_s.opa = i_ahb.hwdata;
            amac_pkg::ADDR_OPB: next_s.opb = i_ahb.hwdata;
            amac_pkg::ADDR_OPC: next_s.opc = i_ahb.hwdata;
            amac_pkg::ADDR_CTRL: next_s.ctrl = i_ahb.hwdata;
            amac_pkg::ADDR_SR: begin
               next_s.sr = i_ahb.hwdata;
               // saturation survives software writes of the flags
               next_s.sr[amac_pkg::SR_Q] = s.sr[amac_pkg::SR_Q];
            end
            amac_pkg::ADDR_RESHI: next_s.res_hi = i_ahb.hwdata;
            amac_pkg::ADDR_ACCLO: begin
               next_s.acc_lo = i_ahb.hwdata;
               next_s.hold_ok = 1'b0;
            end
            amac_pkg::ADDR_ACCHI: begin
               next_s.acc_hi = i_ahb.hwdata[15:0];
               next_s.hold_ok = 1'b0;
            end
            default: begin
            end
         endcase
      end
      unique case (s.st)
         amac_pkg::ST_IDLE: begin
            if (start) begin
               if (mac_w && !s.hold_ok) begin
                  next_s.st = amac_pkg::ST_ACC_READ;
               end else begin
                  next_s.st = amac_pkg::ST_EXEC;
               end
            end
         end
         amac_pkg::ST_ACC_READ: begin
            next_s.hold = {s.acc_hi, s.acc_lo};
            next_s.hold_ok = 1'b1;
            next_s.st = amac_pkg::ST_EXEC;
         end
         amac_pkg::ST_FLAG_WAIT: begin
            if (s.wait_cnt == 2'h0) begin
               next_s.st = amac_pkg::ST_IDLE;
            end else begin
               next_s.wait_cnt = s.wait_cnt - 2'h1;
            end
         end
         amac_pkg::ST_EXEC: begin
            next_s.st = amac_pkg::ST_IDLE;
            unique case (op)
               amac_pkg::OP_OR_HIGH: next_s.opa = rd | {ry[15:0], 16'h0000};
               amac_pkg::OP_OR_LOW: next_s.opa = rd | {16'h0000, ry[15:0]};
               amac_pkg::OP_TEST: begin
                  next_s.sr[amac_pkg::SR_Z] = (rd & rs) == 32'h0000_0000;
                  next_s.sr[amac_pkg::SR_N] = rd[31] & rs[31];
               end
               amac_pkg::OP_FIELD_INS: next_s.opa = (rd & ~(mask << ofs)) | ((rs & mask) << ofs);
               amac_pkg::OP_FIELD_EXT_S: next_s.opa = fld | (fld[5'(wid - 5'h01)] ? ~mask : 32'h0000_0000);
               amac_pkg::OP_FIELD_EXT_U: next_s.opa = fld;
               amac_pkg::OP_BIT_CLR: next_s.opa = rd & ~(32'h0000_0001 << ofs);
               amac_pkg::OP_BIT_SET: next_s.opa = rd | (32'h0000_0001 << ofs);
               amac_pkg::OP_CAST_SB: next_s.opa = {{24{rd[7]}}, rd[7:0]};
               amac_pkg::OP_CAST_SH: next_s.opa = {{16{rd[15]}}, rd[15:0]};
               amac_pkg::OP_CAST_UB: next_s.opa = {24'h00_0000, rd[7:0]};
               amac_pkg::OP_CAST_UH: next_s.opa = {16'h0000, rd[15:0]};
               amac_pkg::OP_SWAP_WORD: next_s.opa = {rd[7:0], rd[15:8], rd[23:16], rd[31:24]};
               amac_pkg::BYTE_EXCHANGE_PER_HALF_OP: next_s.opa = {rd[23:16], rd[31:24], rd[7:0], rd[15:8]};
               amac_pkg::OP_SWAP_HALVES: next_s.opa = {rd[15:0], rd[31:16]};
               amac_pkg::OP_SHIFT_AR: next_s.opa = $signed(rs) >>> amt;
               amac_pkg::OP_SHIFT_LL: next_s.opa = rs << amt;
               amac_pkg::OP_SHIFT_LR: next_s.opa = rs >> amt;
               amac_pkg::OP_ROT_L: begin
                  next_s.opa = {rd[30:0], s.sr[amac_pkg::SR_C]};
                  next_s.sr[amac_pkg::SR_C] = rd[31];
                  next_s.sr[amac_pkg::SR_Z] = {rd[30:0], s.sr[amac_pkg::SR_C]} == 32'h0000_0000;
                  next_s.sr[amac_pkg::SR_N] = rd[30];
               end
               amac_pkg::OP_ROT_R: begin
                  next_s.opa = {s.sr[amac_pkg::SR_C], rd[31:1]};
                  next_s.sr[amac_pkg::SR_C] = rd[0];
                  next_s.sr[amac_pkg::SR_Z] = {s.sr[amac_pkg::SR_C], rd[31:1]} == 32'h0000_0000;
                  next_s.sr[amac_pkg::SR_N] = s.sr[amac_pkg::SR_C];
               end
               amac_pkg::CONDITIONAL_MOVE_OP: begin
                  if (cond_ok) begin
                     next_s.opa = s.ctrl[amac_pkg::CTRL_IMM_BIT] ? ry : rs;
                  end
               end
               amac_pkg::OP_LOAD_HIGH: begin
                  if (CORE_REV >= 2) begin
                     next_s.opa = {ry[15:0], rd[15:0]};
                  end
               end
               amac_pkg::OP_FLAG_CLR: next_s.sr[ofs] = 1'b0;
               amac_pkg::OP_FLAG_COPY: begin
                  next_s.sr[amac_pkg::SR_C] = s.sr[ofs];
                  next_s.sr[amac_pkg::SR_Z] = s.sr[ofs];
               end
               amac_pkg::OP_FLAG_SET: begin
                  next_s.sr[ofs] = 1'b1;
                  // mode bits in the upper half settle over two more cycles
                  if (ofs >= amac_pkg::SSRF_LONG_MIN) begin
                     next_s.st = amac_pkg::ST_FLAG_WAIT;
                     next_s.wait_cnt = amac_pkg::SSRF_EXTRA - 2'h1;
                  end
               end
               amac_pkg::CONDITIONAL_BOOLEAN_OP: next_s.opa = {31'h0000_0000, cond_ok};
               amac_pkg::OP_MUL, amac_pkg::OP_MULHH: next_s.opa = prod[31:0];
               amac_pkg::OP_MULNHH: next_s.opa = -prod[31:0];
               amac_pkg::OP_MULWH: begin
                  next_s.opa = prod[31:0];
                  next_s.res_hi = {{16{prod[47]}}, prod[47:32]};
               end
               amac_pkg::OP_MULNWH: begin
                  next_s.opa = -prod[31:0];
                  next_s.res_hi = {{16{~prod[47]}}, ~prod[47:32]} + {31'h0000_0000, prod[31:0] == 32'h0000_0000};
               end
               amac_pkg::OP_MULSATHH_H: begin
                  next_s.opa = min_hh ? 32'h0000_7FFF : {{16{frac[31]}}, frac[31:16]};
                  next_s.sr[amac_pkg::SR_Q] = s.sr[amac_pkg::SR_Q] | min_hh;
               end
               amac_pkg::OP_MULSATHH_W: begin
                  next_s.opa = min_hh ? 32'h7FFF_FFFF : frac[31:0];
                  next_s.sr[amac_pkg::SR_Q] = s.sr[amac_pkg::SR_Q] | min_hh;
               end
               amac_pkg::OP_MULSATWH: begin
                  next_s.opa = min_wh ? 32'h7FFF_FFFF : frac[47:16];
                  next_s.sr[amac_pkg::SR_Q] = s.sr[amac_pkg::SR_Q] | min_wh;
               end
               amac_pkg::OP_MULSATRNDHH: begin
                  next_s.opa = min_hh ? 32'h0000_7FFF : {{16{rnd[31]}}, rnd[31:16]};
                  next_s.sr[amac_pkg::SR_Q] = s.sr[amac_pkg::SR_Q] | min_hh;
               end
               amac_pkg::OP_MULSATRNDWH: begin
                  next_s.opa = min_wh ? 32'h7FFF_FFFF : rnd[47:16];
                  next_s.sr[amac_pkg::SR_Q] = s.sr[amac_pkg::SR_Q] | min_wh;
               end
               amac_pkg::OP_MAC, amac_pkg::OP_MACHH_W: begin
                  next_s.opa = sum32;
                  next_s.acc_lo = sum32;
                  next_s.acc_hi = {16{sum32[31]}};
                  next_s.hold = {{16{sum32[31]}}, sum32};
               end
               amac_pkg::OP_MACHH_D, amac_pkg::OP_MACWH_D: begin
                  next_s.opa = sum48[31:0];
                  next_s.res_hi = {{16{sum48[47]}}, sum48[47:32]};
                  next_s.acc_lo = sum48[31:0];
                  next_s.acc_hi = sum48[47:32];
                  next_s.hold = sum48;
               end
               amac_pkg::OP_MACSATHH_W: begin
                  next_s.opa = sovf ? (ssum[32] ? 32'h8000_0000 : 32'h7FFF_FFFF) : ssum[31:0];
                  next_s.acc_lo = next_s.opa;
                  next_s.acc_hi = {16{next_s.opa[31]}};
                  next_s.hold = {{16{next_s.opa[31]}}, next_s.opa};
                  next_s.sr[amac_pkg::SR_Q] = s.sr[amac_pkg::SR_Q] | min_hh | sovf;
               end
               default: begin
               end
            endcase
         end
      endcase
      unique case (next_s.dp_addr)
         amac_pkg::ADDR_OPA: next_s.rdata = next_s.opa;
         amac_pkg::ADDR_OPB: next_s.rdata = next_s.opb;
         amac_pkg::ADDR_OPC: next_s.rdata = next_s.opc;
         amac_pkg::ADDR_CTRL: next_s.rdata = next_s.ctrl;
         amac_pkg::ADDR_SR: next_s.rdata = next_s.sr;
         amac_pkg::ADDR_RESHI: next_s.rdata = next_s.res_hi;
         amac_pkg::ADDR_ACCLO: next_s.rdata = next_s.acc_lo;
         amac_pkg::ADDR_ACCHI: next_s.rdata = {16'h0000, next_s.acc_hi};
         amac_pkg::ADDR_STAT: next_s.rdata = {30'h0000_0000, next_s.hold_ok,
            next_s.st != amac_pkg::ST_IDLE};
         default: next_s.rdata = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);

   property p_mac_miss;
      (start && mac_w && !s.hold_ok) |=> s.st == amac_pkg::ST_ACC_READ ##1
         s.st == amac_pkg::ST_EXEC ##1 s.st == amac_pkg::ST_IDLE;
   endproperty
   a_mac_miss: assert property (p_mac_miss) else $error("mac miss timing wrong");

   property p_mac_hit;
      (start && mac_w && s.hold_ok) |=> s.st == amac_pkg::ST_EXEC ##1 !busy;
   endproperty
   a_mac_hit: assert property (p_mac_hit) else $error("mac hit not one cycle");

   property p_flag_set_long;
      (start && op_w == amac_pkg::OP_FLAG_SET &&
       i_ahb.hwdata[amac_pkg::CTRL_OFS_LSB + 4]) |=> busy [*3] ##1 !busy;
   endproperty
   a_flag_set_long: assert property (p_flag_set_long) else $error("flag set not three cycles");

   property p_test_no_write;
      (s.st == amac_pkg::ST_EXEC && op == amac_pkg::OP_TEST) |=> $stable(s.opa);
   endproperty
   a_test_no_write: assert property (p_test_no_write) else $error("test wrote destination");

   property p_q_sticky;
      (s.sr[amac_pkg::SR_Q] && !(s.st == amac_pkg::ST_EXEC &&
       op == amac_pkg::OP_FLAG_CLR && ofs == 5'(amac_pkg::SR_Q))) |=> s.sr[amac_pkg::SR_Q];
   endproperty
   a_q_sticky: assert property (p_q_sticky) else $error("saturation flag lost");

   property p_mul_flags;
      (s.st == amac_pkg::ST_EXEC && op inside {amac_pkg::OP_MUL,
       amac_pkg::OP_MULHH, amac_pkg::OP_MULNHH, amac_pkg::OP_MULWH,
       amac_pkg::OP_MULNWH, amac_pkg::OP_MAC, amac_pkg::OP_MACHH_W,
       amac_pkg::OP_MACHH_D, amac_pkg::OP_MACWH_D}) |=> $stable(s.sr);
   endproperty
   a_mul_flags: assert property (p_mul_flags) else $error("multiply changed flags");

   property p_sat_sets_q;
      (s.st == amac_pkg::ST_EXEC && op == amac_pkg::OP_MULSATHH_H && min_hh)
         |=> s.sr[amac_pkg::SR_Q] && s.opa == 32'h0000_7FFF;
   endproperty
   a_sat_sets_q: assert property (p_sat_sets_q) else $error("saturation not flagged");

   property p_cmove_hold;
      (s.st == amac_pkg::ST_EXEC && op == amac_pkg::CONDITIONAL_MOVE_OP &&
       !cond_ok) |=> $stable(s.opa);
   endproperty
   a_cmove_hold: assert property (p_cmove_hold) else $error("false move wrote");

   property p_bit_set;
      (s.st == amac_pkg::ST_EXEC && op == amac_pkg::OP_BIT_SET) |=>
         s.opa == ($past(s.opa) | (32'h0000_0001 << $past(ofs)));
   endproperty
   a_bit_set: assert property (p_bit_set) else $error("bit set wrong");
   property p_load_high_rev;
      (s.st == amac_pkg::ST_EXEC && op == amac_pkg::OP_LOAD_HIGH &&
       CORE_REV < 2) |=> $stable(s.opa);
   endproperty
   a_load_high_rev: assert property (p_load_high_rev) else $error("load high on old core");
   property p_load_high;
      (s.st == amac_pkg::ST_EXEC && op == amac_pkg::OP_LOAD_HIGH &&
       CORE_REV >= 2) |=> s.opa == {$past(ry[15:0]), $past(rd[15:0])};
   endproperty
   a_load_high: assert property (p_load_high)
      else $error("load high wrong");
endmodule
`default_nettype wire

// ### testbench/amac_bus_model.sv
// Purpose: bus master standing in for decode and pipeline control
// Assumes: one slave, single word transfers, okay response only
// Notes: no fixed wait count; the bench watchdog ends a hang
`timescale 1ns/1ps
`default_nettype none
module amac_bus_model (
   input wire logic i_ref_clk,
   input wire logic i_hready,
   input wire logic [31:0] i_hrdata,
   output var amac_pkg::amac_ahb_req_type o_req
);
   amac_pkg::amac_ahb_req_type r = '0;
   always_comb begin
      o_req = r;
      o_req.hready = i_hready;
   end
   // called just after an edge; holds each phase until hready is seen
   task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      r.hsel <= 1'b1;
      r.haddr <= {24'h00_0000, a};
      r.htrans <= 2'b10;
      r.hwrite <= wr;
      r.hsize <= 3'b010;
      do @(posedge i_ref_clk); while (i_hready !== 1'b1);
      r.htrans <= 2'b00;
      r.hwdata <= d;
      do @(posedge i_ref_clk); while (i_hready !== 1'b1);
      q = i_hrdata;
   endtask
endmodule
`default_nettype wire

// ### testbench/alu_multiply_mac_datapath_test.sv
// Purpose: self-checking bench of the execute datapath
// Assumes: all traffic goes through the bus model
// Notes: reading the result stalls until the operation is done
`timescale 1ns/1ps
`default_nettype none
module alu_multiply_mac_datapath_test;
   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [31:0] hrdata;
   logic hready;
   logic [31:0] v;
   amac_pkg::amac_ahb_req_type req;
   int errors = 0;
   int cmp_count = 0;
   always #20 i_ref_clk = ~i_ref_clk;
   amac_bus_model bus (.i_ref_clk(i_ref_clk), .i_hready(hready),
      .i_hrdata(hrdata), .o_req(req));
   amac_datapath dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ahb(req),
      .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(), .o_busy());
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus.xfer(1'b1, a, d, v);
   endtask
   task automatic chk(input logic [7:0] a, input logic [31:0] e);
      bus.xfer(1'b0, a, 32'h0, v);
      cmp_count++;
      if (v !== e) begin
         errors++;
         $display("MISMATCH t=%0t addr %h got %h exp %h", $time, a, v, e);
      end
   endtask
   // dest, source, third operand, then control word starts the op
   task automatic op(input logic [31:0] a, b, c, k, e);
      wr(amac_pkg::ADDR_OPA, a);
      wr(amac_pkg::ADDR_OPB, b);
      wr(amac_pkg::ADDR_OPC, c);
      wr(amac_pkg::ADDR_CTRL, k);
      chk(amac_pkg::ADDR_OPA, e);
   endtask
   task automatic t_bits();
      op(32'hFFFF_0000, 32'h5, 32'h0, 32'h0003_0403, 32'hFFFF_0050);
      op(32'h0, 32'hF0, 32'h0, 32'h0004_0404, 32'hFFFF_FFFF);
      op(32'h0, 32'hF0, 32'h0, 32'h0004_0405, 32'hF);
      op(32'h80, 32'h0, 32'h0, 32'h8, 32'hFFFF_FF80);
      op(32'h0, 32'h0, 32'h0, 32'h0000_1F07, 32'h8000_0000);
      op(32'h1122_3344, 32'h0, 32'h0, 32'hC, 32'h4433_2211);
      op(32'h1122_3344, 32'h0, 32'h0, 32'hD, 32'h2211_4433);
      op(32'h1122_3344, 32'h0, 32'h0, 32'hE, 32'h3344_1122);
      $display("test bits done");
   endtask
   task automatic t_shift();
      op(32'h0, 32'h8000_0000, 32'h0, 32'h0400_0411, 32'h0800_0000);
      op(32'h0, 32'h8000_0000, 32'h4, 32'hF, 32'hF800_0000);
      wr(amac_pkg::ADDR_SR, 32'h1);
      op(32'h8000_0000, 32'h0, 32'h0, 32'h12, 32'h1);
      chk(amac_pkg::ADDR_SR, 32'h1);
      $display("test shift done");
   endtask
   task automatic t_cond();
      wr(amac_pkg::ADDR_SR, 32'h0);
      op(32'hAAAA, 32'h5555, 32'h0, 32'h14, 32'hAAAA);
      wr(amac_pkg::ADDR_SR, 32'h2);
      op(32'hAAAA, 32'h5555, 32'h0, 32'h14, 32'h5555);
      $display("test cond done");
   endtask
   task automatic t_flags();
      wr(amac_pkg::ADDR_SR, 32'h0);
      wr(amac_pkg::ADDR_CTRL, 32'h0000_1418);
      chk(amac_pkg::ADDR_SR, 32'h0010_0000);
      op(32'h0, 32'h8000, 32'h8000, 32'h1F, 32'h7FFF);
      chk(amac_pkg::ADDR_SR, 32'h0010_0010);
      wr(amac_pkg::ADDR_SR, 32'h0010_0000);
      chk(amac_pkg::ADDR_SR, 32'h0010_0010);
      wr(amac_pkg::ADDR_CTRL, 32'h0000_0416);
      chk(amac_pkg::ADDR_SR, 32'h0010_0000);
      $display("test flags done");
   endtask
   task automatic t_misc();
      wr(amac_pkg::ADDR_SR, 32'h0);
      op(32'h1234_5678, 32'h0, 32'hF0, 32'h0, 32'h12F4_5678);
      op(32'h1234_5678, 32'h0, 32'hF0, 32'h1, 32'h1234_56F8);
      op(32'hF0, 32'hF, 32'h0, 32'h2, 32'hF0);
      chk(amac_pkg::ADDR_SR, 32'h2);
      wr(amac_pkg::ADDR_SR, 32'h4);
      wr(amac_pkg::ADDR_CTRL, 32'h0000_0217);
      chk(amac_pkg::ADDR_SR, 32'h7);
      op(32'h1234, 32'h0, 32'h0, 32'h1000_0019, 32'h0);
      op(32'h1234, 32'h0, 32'h0, 32'h19, 32'h1);
      op(32'h1234_5678, 32'h0, 32'hABCD, 32'h15, 32'hABCD_5678);
      $display("test misc done");
   endtask
   task automatic t_mul();
      wr(amac_pkg::ADDR_SR, 32'h0);
      op(32'h0, 32'h0001_0003, 32'h100, 32'h1A, 32'h0100_0300);
      chk(amac_pkg::ADDR_SR, 32'h0);
      op(32'h0, 32'h4000_0000, 32'h4, 32'h1D, 32'h0);
      chk(amac_pkg::ADDR_RESHI, 32'h1);
      op(32'h0, 32'h4000_0000, 32'h4, 32'h1E, 32'h0);
      chk(amac_pkg::ADDR_RESHI, 32'hFFFF_FFFF);
      op(32'h0, 32'h4000, 32'h1, 32'h22, 32'h1);
      wr(amac_pkg::ADDR_ACCLO, 32'hFFFF_FFFF);
      wr(amac_pkg::ADDR_ACCHI, 32'h0);
      op(32'h0, 32'h1, 32'h1, 32'h27, 32'h0);
      chk(amac_pkg::ADDR_ACCHI, 32'h1);
      chk(amac_pkg::ADDR_SR, 32'h0);
      op(32'h0, 32'h8000, 32'h8000, 32'h28, 32'h7FFF_FFFF);
      chk(amac_pkg::ADDR_SR, 32'h10);
      wr(amac_pkg::ADDR_CTRL, 32'h0000_0416);
      $display("test mul done");
   endtask
   task automatic t_mac();
      wr(amac_pkg::ADDR_ACCLO, 32'h5);
      wr(amac_pkg::ADDR_ACCHI, 32'h0);
      chk(amac_pkg::ADDR_STAT, 32'h0);
      op(32'h0, 32'h3, 32'h4, 32'h24, 32'h11);
      chk(amac_pkg::ADDR_STAT, 32'h2);
      op(32'h0, 32'h3, 32'h4, 32'h24, 32'h1D);
      chk(8'h40, 32'h0);
      $display("test mac done");
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #400000;
      errors++;
      results();
   end
   initial begin
      repeat (10) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      @(posedge i_ref_clk);
      t_bits();
      t_shift();
      t_cond();
      t_misc();
      t_flags();
      t_mul();
      t_mac();
      results();
   end
endmodule
`default_nettype wire
